// >>> pkg/mie_pkg.sv
// Package of register offsets, field layouts and reset values for the MAC interrupt enable block.
package mie_pkg;

  // ==========================================================================
  // Bus widths
  // ==========================================================================
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [ADDR_W-1:0] MAC_IRQ_ENABLE_ADDR = 32'hb00030ac;
  localparam logic [ADDR_W-1:0] MAC_IRQ_STATUS_ADDR = 32'hb00030b0;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 32'hb00030c0;
  localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 32'hb00030c4;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned TX_MASTER_BIT = 16;
  localparam int unsigned RX_MASTER_BIT = 0;
  localparam int unsigned TX_SRC_HI = 24;
  localparam int unsigned TX_SRC_LO = 17;
  localparam int unsigned RX_SRC_HI = 7;
  localparam int unsigned RX_SRC_LO = 1;
  localparam int unsigned RX_PAUSE_BIT = 14;
  localparam int unsigned RX_BUS_FAULT_BIT = 11;
  localparam int unsigned RX_NO_DESC_BIT = 10;
  localparam int unsigned RX_EARLY_BIT = 9;
  localparam int unsigned RX_MAXLEN_BIT = 8;
  localparam int unsigned EVT_TX_BIT = 1;
  localparam int unsigned EVT_RX_BIT = 0;

  // Writable bits of the enable register; all others are reserved.
  localparam logic [DATA_W-1:0] TX_SRC_MASK = 32'h01fe0000;
  localparam logic [DATA_W-1:0] RX_SRC_MASK = 32'h00004ffe;
  localparam logic [DATA_W-1:0] MASTER_MASK = 32'h00010001;
  localparam logic [DATA_W-1:0] ENABLE_MASK = TX_SRC_MASK | RX_SRC_MASK | MASTER_MASK;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DATA_W-1:0] MAC_IRQ_ENABLE_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] MAC_IRQ_STATUS_RST = 32'h00000000;
  localparam logic [1:0] EVENT_STATUS_RST = 2'h0;
  localparam logic [1:0] EVENT_MASK_RST = 2'h0;

endpackage : mie_pkg

// >>> design/mie_irq_enable.sv
// MAC interrupt enable, status and transmit/receive interrupt generation.
//
// Added by the designer: strobed register access.

// Functional notes
// - Separate transmit and receive interrupt lines.
// - Transmit source enables at bits 24 to 17.
// - Transmit irq needs status, source enable, master.
// - Transmit master cleared blocks all transmit irqs.
// - Cleared source enable excludes its status bit.
// - Receive enables at bits 14, 11..8.
// - Receive source enables at bits 7 to 1.
// - Receive irq needs master bit 0 and status.
// - Receive master cleared blocks all receive irqs.
// - Disabled receive source never contributes.
// - Enable register resets to zero.
// - Writing one clears a status bit.
module mie_irq_enable (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [mie_pkg::ADDR_W-1:0] regAddr,
  input wire logic [mie_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [mie_pkg::DATA_W-1:0] regRdData,
  // Status events from the MAC datapath, one-cycle pulses per bit
  input wire logic [mie_pkg::DATA_W-1:0] statusSet,
  // Interrupts toward the CPU
  output logic transmitIrq,
  output logic receiveIrq,
  output logic eventIrq
);
  import mie_pkg::*;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [DATA_W-1:0] enable_reg;
  logic [DATA_W-1:0] status_reg;
  logic [1:0] evtStatus_reg;
  logic [1:0] evtMask_reg;
  logic txIrq_reg;
  logic rxIrq_reg;
  logic evtIrq_reg;
  logic [DATA_W-1:0] rdData_reg;

  logic wrEnable;
  logic wrStatus;
  logic wrEvtStatus;
  logic wrEvtMask;
  logic rdEvtStatus;
  logic txCombined;
  logic rxCombined;
  logic txIrq_next;
  logic rxIrq_next;
  logic [1:0] evtRise;
  logic [DATA_W-1:0] statusView;
  logic [DATA_W-1:0] rdData_next;

  assign wrEnable = regWrite && (regAddr == MAC_IRQ_ENABLE_ADDR);
  assign wrStatus = regWrite && (regAddr == MAC_IRQ_STATUS_ADDR);
  assign wrEvtStatus = regWrite && (regAddr == EVENT_STATUS_ADDR);
  assign wrEvtMask = regWrite && (regAddr == EVENT_MASK_ADDR);
  assign rdEvtStatus = regRead && (regAddr == EVENT_STATUS_ADDR);

  // ==========================================================================
  // Named enable fields
  // ==========================================================================
  // Each source is spelled out by name so that a wrong bit position shows up
  // as a wrong name here, not as a silent slip inside a mask constant.
  logic transmitMasterEnable;
  assign transmitMasterEnable = enable_reg[TX_MASTER_BIT];
  logic receiveMasterEnable;
  assign receiveMasterEnable = enable_reg[RX_MASTER_BIT];
  logic enTransmitBusFault;
  assign enTransmitBusFault = enable_reg[TX_SRC_LO + 7];
  logic enTransmitNoDescriptor;
  assign enTransmitNoDescriptor = enable_reg[TX_SRC_LO + 6];
  logic enLateCollision;
  assign enLateCollision = enable_reg[TX_SRC_LO + 5];
  logic enTransmitAborted;
  assign enTransmitAborted = enable_reg[TX_SRC_LO + 4];
  logic enNoCarrier;
  assign enNoCarrier = enable_reg[TX_SRC_LO + 3];
  logic enDeferralOvertime;
  assign enDeferralOvertime = enable_reg[TX_SRC_LO + 2];
  logic enTransmitDone;
  assign enTransmitDone = enable_reg[TX_SRC_LO + 1];
  logic enTransmitUnderflow;
  assign enTransmitUnderflow = enable_reg[TX_SRC_LO];
  logic enPauseFrameSeen;
  assign enPauseFrameSeen = enable_reg[RX_PAUSE_BIT];
  logic enReceiveBusFault;
  assign enReceiveBusFault = enable_reg[RX_BUS_FAULT_BIT];
  logic enReceiveNoDescriptor;
  assign enReceiveNoDescriptor = enable_reg[RX_NO_DESC_BIT];
  logic enEarlyNotice;
  assign enEarlyNotice = enable_reg[RX_EARLY_BIT];
  logic enMaxLengthExceeded;
  assign enMaxLengthExceeded = enable_reg[RX_MAXLEN_BIT];
  logic enManyMissed;
  assign enManyMissed = enable_reg[RX_SRC_LO + 6];
  logic enShortFrame;
  assign enShortFrame = enable_reg[RX_SRC_LO + 5];
  logic enAlignmentFault;
  assign enAlignmentFault = enable_reg[RX_SRC_LO + 4];
  logic enReceiveOk;
  assign enReceiveOk = enable_reg[RX_SRC_LO + 3];
  logic enFrameTooLong;
  assign enFrameTooLong = enable_reg[RX_SRC_LO + 2];
  logic enReceiveOverflow;
  assign enReceiveOverflow = enable_reg[RX_SRC_LO + 1];
  logic enChecksumFault;
  assign enChecksumFault = enable_reg[RX_SRC_LO];

  // ==========================================================================
  // Named status fields
  // ==========================================================================
  logic transmitBusFault;
  assign transmitBusFault = status_reg[TX_SRC_LO + 7];
  logic transmitNoDescriptor;
  assign transmitNoDescriptor = status_reg[TX_SRC_LO + 6];
  logic lateCollision;
  assign lateCollision = status_reg[TX_SRC_LO + 5];
  logic transmitAborted;
  assign transmitAborted = status_reg[TX_SRC_LO + 4];
  logic noCarrier;
  assign noCarrier = status_reg[TX_SRC_LO + 3];
  logic deferralOvertime;
  assign deferralOvertime = status_reg[TX_SRC_LO + 2];
  logic transmitDone;
  assign transmitDone = status_reg[TX_SRC_LO + 1];
  logic transmitUnderflow;
  assign transmitUnderflow = status_reg[TX_SRC_LO];
  logic pauseFrameSeen;
  assign pauseFrameSeen = status_reg[RX_PAUSE_BIT];
  logic receiveBusFault;
  assign receiveBusFault = status_reg[RX_BUS_FAULT_BIT];
  logic receiveNoDescriptor;
  assign receiveNoDescriptor = status_reg[RX_NO_DESC_BIT];
  logic earlyNotice;
  assign earlyNotice = status_reg[RX_EARLY_BIT];
  logic maxLengthExceeded;
  assign maxLengthExceeded = status_reg[RX_MAXLEN_BIT];
  logic manyMissed;
  assign manyMissed = status_reg[RX_SRC_LO + 6];
  logic shortFrame;
  assign shortFrame = status_reg[RX_SRC_LO + 5];
  logic alignmentFault;
  assign alignmentFault = status_reg[RX_SRC_LO + 4];
  logic receiveOk;
  assign receiveOk = status_reg[RX_SRC_LO + 3];
  logic frameTooLong;
  assign frameTooLong = status_reg[RX_SRC_LO + 2];
  logic receiveOverflow;
  assign receiveOverflow = status_reg[RX_SRC_LO + 1];
  logic checksumFault;
  assign checksumFault = status_reg[RX_SRC_LO];

  // ==========================================================================
  // Enable register
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= MAC_IRQ_ENABLE_RST;
    end else if (wrEnable) begin
      // Reserved bits are never stored, so they always read back as zero.
      enable_reg <= regWrData & ENABLE_MASK;
    end
  end

  // ==========================================================================
  // Status register
  // ==========================================================================
  // A source pulse in the same cycle as a write-one clear keeps the bit set,
  // so no event is lost to a racing clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= MAC_IRQ_STATUS_RST;
    end else begin
      status_reg <= ((status_reg & ~(wrStatus ? regWrData : '0)) | statusSet)
                    & (TX_SRC_MASK | RX_SRC_MASK);
    end
  end

  // ==========================================================================
  // Interrupt combination
  // ==========================================================================
  always_comb begin
    // Each status bit only counts through its own enable bit.
    txCombined = (transmitBusFault & enTransmitBusFault)
                 | (transmitNoDescriptor & enTransmitNoDescriptor)
                 | (lateCollision & enLateCollision)
                 | (transmitAborted & enTransmitAborted)
                 | (noCarrier & enNoCarrier)
                 | (deferralOvertime & enDeferralOvertime)
                 | (transmitDone & enTransmitDone)
                 | (transmitUnderflow & enTransmitUnderflow);
    rxCombined = (pauseFrameSeen & enPauseFrameSeen)
                 | (receiveBusFault & enReceiveBusFault)
                 | (receiveNoDescriptor & enReceiveNoDescriptor)
                 | (earlyNotice & enEarlyNotice)
                 | (maxLengthExceeded & enMaxLengthExceeded)
                 | (manyMissed & enManyMissed)
                 | (shortFrame & enShortFrame)
                 | (alignmentFault & enAlignmentFault)
                 | (receiveOk & enReceiveOk)
                 | (frameTooLong & enFrameTooLong)
                 | (receiveOverflow & enReceiveOverflow)
                 | (checksumFault & enChecksumFault);
    // The receive line uses its own master bit, not the transmit one.
    txIrq_next = txCombined && transmitMasterEnable;
    rxIrq_next = rxCombined && receiveMasterEnable;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txIrq_reg <= 1'b0;
      rxIrq_reg <= 1'b0;
    end else begin
      txIrq_reg <= txIrq_next;
      rxIrq_reg <= rxIrq_next;
    end
  end

  // ==========================================================================
  // Event summary: rising edges of the two interrupt lines
  // ==========================================================================
  assign evtRise = {txIrq_next & ~txIrq_reg, rxIrq_next & ~rxIrq_reg};

  // Reading the summary clears it, but a rise in that same cycle survives.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evtStatus_reg <= EVENT_STATUS_RST;
    end else begin
      evtStatus_reg <= (rdEvtStatus ? 2'h0 : evtStatus_reg) | evtRise;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evtMask_reg <= EVENT_MASK_RST;
    end else if (wrEvtMask) begin
      evtMask_reg <= regWrData[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evtIrq_reg <= 1'b0;
    end else begin
      evtIrq_reg <= |(((rdEvtStatus ? 2'h0 : evtStatus_reg) | evtRise) & evtMask_reg);
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // The combined bits of the status view show the live OR of enabled sources.
  always_comb begin
    statusView = status_reg;
    statusView[TX_MASTER_BIT] = txCombined;
    statusView[RX_MASTER_BIT] = rxCombined;
    rdData_next = '0;
    if (regRead) begin
      unique case (regAddr)
        MAC_IRQ_ENABLE_ADDR: rdData_next = enable_reg;
        MAC_IRQ_STATUS_ADDR: rdData_next = statusView;
        EVENT_STATUS_ADDR: rdData_next = {30'h0, evtStatus_reg};
        EVENT_MASK_ADDR: rdData_next = {30'h0, evtMask_reg};
        default: rdData_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;
  assign transmitIrq = txIrq_reg;
  assign receiveIrq = rxIrq_reg;
  assign eventIrq = evtIrq_reg;

  // wrEvtStatus is decoded for completeness; the summary is read-to-clear only.
  logic unusedWr;
  assign unusedWr = wrEvtStatus;

endmodule // mie_irq_enable

// >>> tb/mie_irq_enable_monitor.sv
// Checker watching the ports of the MAC interrupt enable block.
module mie_irq_enable_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [mie_pkg::ADDR_W-1:0] regAddr,
  input wire logic [mie_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [mie_pkg::DATA_W-1:0] regRdData,
  // Events and interrupts
  input wire logic [mie_pkg::DATA_W-1:0] statusSet,
  input wire logic transmitIrq,
  input wire logic receiveIrq,
  input wire logic eventIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  import mie_pkg::*;
  logic [DATA_W-1:0] enReg;
  // Shadow of the enable register, so enable reads and the transmit and receive irqs can be tied to their cause.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) enReg <= '0;
    else if (regWrite && regAddr == MAC_IRQ_ENABLE_ADDR) enReg <= regWrData & ENABLE_MASK;
  end
  // ====================
  // Assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rdIdle_a: assert property (!$past(regRead) |-> regRdData == '0)
    else $error("read data outside read slot");
  enRead_a: assert property ($past(regRead) && $past(regAddr) == MAC_IRQ_ENABLE_ADDR
    |-> regRdData == $past(enReg)) else $error("enable read back wrong");
  txMaster_a: assert property (!$past(enReg[TX_MASTER_BIT]) |-> !transmitIrq)
    else $error("transmit irq without master");
  rxMaster_a: assert property (!$past(enReg[RX_MASTER_BIT]) |-> !receiveIrq)
    else $error("receive irq without master");
  txSrc_a: assert property (($past(enReg) & TX_SRC_MASK) == '0 |-> !transmitIrq)
    else $error("transmit irq without source");
  rxSrc_a: assert property (($past(enReg) & RX_SRC_MASK) == '0 |-> !receiveIrq)
    else $error("receive irq without source");
  txRise_a: assert property (!regWrite && enReg[TX_MASTER_BIT] &&
    |(statusSet & enReg & TX_SRC_MASK) |-> ##2 transmitIrq) else $error("transmit irq late");
  rxRise_a: assert property (!regWrite && enReg[RX_MASTER_BIT] &&
    |(statusSet & enReg & RX_SRC_MASK) |-> ##2 receiveIrq) else $error("receive irq late");
endmodule // mie_irq_enable_monitor

// >>> tb/mie_cpu_model.sv
// Model of the CPU side interrupt controller that counts transmit requests.
module mie_cpu_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Interrupt line and request count
  input wire logic transmitIrq,
  output logic [7:0] txReqs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Request counter
  // A level held high is one request, so only its rise is counted.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) txReqs <= 8'h0;
    else txReqs <= txReqs + 8'($rose(transmitIrq));
  end
endmodule // mie_cpu_model

// >>> tb/mie_irq_enable_tb.sv
// Self-checking bench of the MAC interrupt enable block.
module mie_irq_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mie_pkg::*;
  typedef struct {logic [31:0] en; logic [31:0] st; logic [1:0] irq;} mie_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regAddr = '0, regWrData = '0, statusSet = '0, regRdData, rdVal;
  logic transmitIrq, receiveIrq, eventIrq;
  logic [7:0] txReqs;
  int miscompares = 0, numChecks = 0, expTx = 0;
  // ====================
  // Rows: enable value, status pulse, then transmit and receive levels.
  mie_row_t rows[9] = '{'{32'h01fe0001, 32'h01fe0000, 2'h0}, '{32'h00050000, 32'h00040000, 2'h2},
    '{32'h00010000, 32'h01fe0000, 2'h0}, '{32'h00004ffe, 32'h00004ffe, 2'h0},
    '{32'h00000101, 32'h00000100, 2'h1}, '{32'h00004001, 32'h00004000, 2'h1},
    '{32'h00000003, 32'h000000fc, 2'h0}, '{32'hffffffff, 32'h00000080, 2'h1},
    '{32'h01010000, 32'h01000000, 2'h2}};
  always #5 ref_clk = ~ref_clk;
  mie_irq_enable u_mie_irq_enable (.*);
  mie_cpu_model u_mie_cpu_model (.*);
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // A write leaves rdVal at zero, since read data stands only after a read.
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, d};
    @(posedge ref_clk);
    {regWrite, regRead} <= 2'h0;
    #1 rdVal = regRdData;
  endtask
  task automatic pulse(input logic [31:0] s);
    @(posedge ref_clk);
    statusSet <= s;
    @(posedge ref_clk);
    statusSet <= '0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic printVerdict();
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20us;
    miscompares++;
    printVerdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    acc(1'b0, MAC_IRQ_ENABLE_ADDR, '0);
    chk("enable at reset", 32'h0, rdVal);
    acc(1'b0, 32'hb00030b8, '0);
    chk("unmapped read", 32'h0, rdVal);
    foreach (rows[i]) begin
      acc(1'b1, MAC_IRQ_ENABLE_ADDR, rows[i].en);
      acc(1'b0, MAC_IRQ_ENABLE_ADDR, '0);
      chk("enable", rows[i].en & 32'h01ff4fff, rdVal);
      pulse(rows[i].st);
      chk("irqs", {30'h0, rows[i].irq}, {30'h0, transmitIrq, receiveIrq});
      expTx += rows[i].irq[1];
      acc(1'b1, MAC_IRQ_STATUS_ADDR, 32'hffffffff);
    end
    acc(1'b0, EVENT_STATUS_ADDR, '0);
    acc(1'b1, EVENT_MASK_ADDR, 32'h1);
    acc(1'b1, MAC_IRQ_ENABLE_ADDR, 32'h00050000);
    pulse(32'h00040000);
    chk("tx requests", 32'(expTx + 1), 32'(txReqs));
    chk("masked event", 32'h0, {31'h0, eventIrq});
    acc(1'b1, EVENT_MASK_ADDR, 32'h2);
    acc(1'b1, MAC_IRQ_STATUS_ADDR, 32'h0);
    pulse('0);
    chk("event and tx kept", 32'h3, {30'h0, eventIrq, transmitIrq});
    acc(1'b0, EVENT_STATUS_ADDR, '0);
    chk("event summary", 32'h2, rdVal);
    acc(1'b1, MAC_IRQ_STATUS_ADDR, 32'h00040000);
    pulse('0);
    chk("cleared", 32'h0, {30'h0, eventIrq, transmitIrq});
    acc(1'b1, MAC_IRQ_ENABLE_ADDR, 32'h00050000);
    pulse(32'h00040000);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("tx after reset", 32'h0, {31'h0, transmitIrq});
    acc(1'b0, MAC_IRQ_ENABLE_ADDR, '0);
    chk("enable after reset", 32'h0, rdVal);
    printVerdict();
  end
endmodule // mie_irq_enable_tb
bind mie_irq_enable mie_irq_enable_monitor u_mie_irq_enable_monitor (.*);
